// *** amc_mode_ctrl.sv ***
// mode register and operation sequencer for an eight-channel converter
`timescale 1ns/1ps
module amc_mode_ctrl #(
    parameter int NCH = amc_pkg::AMC_NCH,
    parameter int W = amc_pkg::AMC_DATA_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [7:0] chan_enable,
    input wire logic crystal_mode,
    input wire logic master_clock_in_pin,
    output logic master_clock_out_pin_o,
    output logic master_clock_out_pin_oe,
    input wire logic [W-1:0] conv_raw,
    input wire logic conv_over,
    input wire logic conv_under,
    output logic [7:0] adc_status,
    output logic done_n,
    output logic [2:0] active_chan,
    output logic [1:0] conv_slot,
    output logic cal_active,
    output logic standby,
    output logic chain_readout,
    output logic cont_readout,
    output logic [W-1:0] chan_data,
    output logic [2:0] chan_data_idx,
    output logic chan_data_valid
);
    import amc_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [2:0] next_enabled(input logic [2:0] cur, input logic [7:0] en);
        logic [2:0] n;
        logic [2:0] k;
        logic found;
        n = cur;
        found = 1'b0;
        for (int i = 1; i <= NCH; i++) begin
            k = 3'(cur + 3'(i));
            if (!found && en[k]) begin
                n = k;
                found = 1'b1;
            end
        end
        return n;
    endfunction : next_enabled

    function automatic logic is_cal(input logic [2:0] op);
        return op[2];
    endfunction : is_cal

    typedef struct packed {
        amc_state_t state;
        logic [7:0] mode;
        logic [2:0] operand;
        logic [15:0] cnt;
        logic [7:0] status;
        logic done_n;
        logic [2:0] chan;
        logic [7:0] rdata;
        logic rvalid;
        logic [W-1:0] data;
        logic [2:0] data_idx;
        logic data_valid;
        logic mclk_o;
        logic mclk_oe;
    } amc_st_t;

    amc_st_t st_r;
    amc_st_t st_nxt;
    logic mclk_sync;
    logic [W-1:0] fmt;
    logic clk_ok;
    logic hit;

    // ****************************************
    // submodules
    // ****************************************
    amc_sync u_mclk_sync (
        .clk(clk),
        .rstn(rstn),
        .din(master_clock_in_pin),
        .dout(mclk_sync)
    );

    amc_result #(.W(W)) u_result (
        .raw(conv_raw),
        .over(conv_over),
        .under(conv_under),
        .clamp_en(st_r.mode[AMC_CLAMP_BIT]),
        .wide(st_r.mode[AMC_WIDTH_BIT]),
        .result(fmt)
    );

    // ****************************************
    // next state
    // ****************************************
    // crystal clock stops when its output is disabled; external clock runs on
    assign clk_ok = !(crystal_mode && st_r.mode[AMC_CLOCK_OUT_DISABLE_BIT]);
    assign hit = (reg_addr & AMC_MODE_MASK) == AMC_MODE_BASE;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.data_valid = 1'b0;
        st_nxt.mclk_o = mclk_sync;
        if (reg_rd && reg_addr == AMC_MODE_BASE) begin
            st_nxt.rdata = st_r.mode;
            st_nxt.rvalid = 1'b1;
        end
        if (reg_wr && hit) begin
            st_nxt.mode = reg_wdata;
            st_nxt.operand = reg_addr[2:0];
            st_nxt.status = AMC_ZERO8;
            st_nxt.done_n = 1'b1;
            st_nxt.cnt = '0;
            st_nxt.chan = reg_addr[2:0];
            // abort and restart immediately
            case (amc_op_t'(reg_wdata[AMC_OPSEL_HI:AMC_OPSEL_LO]))
                AMC_OP_CONT, AMC_OP_SINGLE: st_nxt.state = AMC_ST_CONV;
                AMC_OP_STANDBY: st_nxt.state = AMC_ST_STBY;
                AMC_OP_ZS_SELF, AMC_OP_FS_SELF,
                AMC_OP_ZS_SYS, AMC_OP_FS_SYS: st_nxt.state = AMC_ST_CAL;
                default: st_nxt.state = AMC_ST_IDLE;
            endcase
        end else begin
            case (st_r.state)
                AMC_ST_CONV: begin
                    if (clk_ok) begin
                        st_nxt.cnt = 16'(st_r.cnt + 16'h0001);
                    end
                    if (clk_ok && st_r.cnt == AMC_CONV_CYCLES - 16'h0001) begin
                        st_nxt.cnt = '0;
                        st_nxt.data = fmt;
                        st_nxt.data_idx = st_r.chan;
                        st_nxt.data_valid = 1'b1;
                        st_nxt.status[st_r.chan] = 1'b1;
                        if (st_r.mode[AMC_OPSEL_HI:AMC_OPSEL_LO] == AMC_OP_CONT) begin
                            st_nxt.chan = next_enabled(st_r.chan, chan_enable);
                        end else begin
                            st_nxt.done_n = 1'b0;
                            st_nxt.mode[AMC_OPSEL_HI:AMC_OPSEL_LO] = AMC_OP_IDLE;
                            st_nxt.state = AMC_ST_IDLE;
                        end
                    end
                end
                AMC_ST_CAL: begin
                    if (clk_ok) begin
                        st_nxt.cnt = 16'(st_r.cnt + 16'h0001);
                    end
                    if (clk_ok && st_r.cnt == AMC_CAL_CYCLES - 16'h0001) begin
                        st_nxt.cnt = '0;
                        st_nxt.status = AMC_ALL_READY;
                        st_nxt.done_n = 1'b0;
                        st_nxt.mode[AMC_OPSEL_HI:AMC_OPSEL_LO] = AMC_OP_IDLE;
                        st_nxt.state = AMC_ST_IDLE;
                    end
                end
                AMC_ST_STBY: st_nxt.state = AMC_ST_STBY;
                AMC_ST_IDLE: st_nxt.state = AMC_ST_IDLE;
                default: st_nxt.state = AMC_ST_IDLE;
            endcase
        end
        // pin enable follows the disable bit in the same cycle as the mode write
        st_nxt.mclk_oe = !st_nxt.mode[AMC_CLOCK_OUT_DISABLE_BIT];
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.state <= AMC_ST_IDLE;
            st_r.mode <= AMC_MODE_RESET;
            st_r.done_n <= 1'b1;
            st_r.mclk_oe <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign master_clock_out_pin_o = st_r.mclk_o;
    assign master_clock_out_pin_oe = st_r.mclk_oe;
    assign adc_status = st_r.status;
    assign done_n = st_r.done_n;
    assign active_chan = st_r.chan;
    assign conv_slot = st_r.operand[1:0];
    assign cal_active = st_r.state == AMC_ST_CAL;
    assign standby = st_r.state == AMC_ST_STBY;
    assign chain_readout = st_r.mode[AMC_CHAIN_BIT] | st_r.mode[AMC_CONTRD_BIT];
    assign cont_readout = st_r.mode[AMC_CONTRD_BIT];
    assign chan_data = st_r.data;
    assign chan_data_idx = st_r.data_idx;
    assign chan_data_valid = st_r.data_valid;
endmodule : amc_mode_ctrl

// *** amc_pkg.sv ***
// package: register map, field layout and mode codes for the mode control block
package amc_pkg;
    localparam logic [5:0] AMC_MODE_BASE = 6'h38;
    localparam logic [5:0] AMC_MODE_MASK = 6'h38;
    localparam logic [7:0] AMC_MODE_RESET = 8'h00;
    localparam int AMC_OPSEL_HI = 7;
    localparam int AMC_OPSEL_LO = 5;
    localparam int AMC_CLOCK_OUT_DISABLE_BIT = 4;
    localparam int AMC_CHAIN_BIT = 3;
    localparam int AMC_CONTRD_BIT = 2;
    localparam int AMC_WIDTH_BIT = 1;
    localparam int AMC_CLAMP_BIT = 0;
    localparam int AMC_NCH = 8;
    localparam int AMC_DATA_W = 24;
    localparam logic [7:0] AMC_ALL_READY = 8'hFF;
    localparam logic [7:0] AMC_ZERO8 = 8'h00;
    localparam logic [15:0] AMC_CONV_CYCLES = 16'h0040;
    localparam logic [15:0] AMC_CAL_CYCLES = 16'h0080;
    typedef enum logic [2:0] {
        AMC_OP_IDLE = 3'h0,
        AMC_OP_CONT = 3'h1,
        AMC_OP_SINGLE = 3'h2,
        AMC_OP_STANDBY = 3'h3,
        AMC_OP_ZS_SELF = 3'h4,
        AMC_OP_FS_SELF = 3'h5,
        AMC_OP_ZS_SYS = 3'h6,
        AMC_OP_FS_SYS = 3'h7
    } amc_op_t;
    typedef enum logic [3:0] {
        AMC_ST_IDLE = 4'h1,
        AMC_ST_CONV = 4'h2,
        AMC_ST_CAL = 4'h4,
        AMC_ST_STBY = 4'h8
    } amc_state_t;
endpackage : amc_pkg

// *** amc_sync.sv ***
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module amc_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } amc_sync_t;
    amc_sync_t st_r;
    amc_sync_t st_nxt;
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.q = st_r.s3;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign dout = st_r.q;
endmodule : amc_sync

// *** amc_result.sv ***
// result formatter: clamping and 16/24-bit width
`timescale 1ns/1ps
module amc_result #(
    parameter int W = amc_pkg::AMC_DATA_W
) (
    input wire logic [W-1:0] raw,
    input wire logic over,
    input wire logic under,
    input wire logic clamp_en,
    input wire logic wide,
    output logic [W-1:0] result
);
    import amc_pkg::*;
    logic [W-1:0] c;
    always_comb begin
        c = raw;
        if (clamp_en && over) begin
            c = '1;
        end else if (clamp_en && under) begin
            c = '0;
        end
        // unclamped input passes through at 24-bit width; 16-bit width keeps its top 16 bits
        result = wide ? c : {8'h00, c[W-1:8]};
    end
endmodule : amc_result

// *** amc_mode_ctrl_checker.sv ***
// checker: port assertions for the mode control block
`timescale 1ns/1ps
module amc_mode_ctrl_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic master_clock_out_pin_oe,
    input wire logic [7:0] adc_status,
    input wire logic done_n,
    input wire logic cal_active,
    input wire logic standby,
    input wire logic chain_readout,
    input wire logic cont_readout
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_wr;
        reg_wr && reg_addr[5:3] == 3'h7;
    endsequence
    sequence s_op(logic [2:0] op);
        reg_wr && reg_addr[5:3] == 3'h7 && reg_wdata[7:5] == op;
    endsequence
    sequence s_rd;
        reg_rd && reg_addr == 6'h38;
    endsequence
    AST_WR_CLEAR: assert property (s_wr |=> done_n && adc_status == 8'h00)
        else $error("mode write did not clear status and done");
    AST_RD_ANSWER: assert property (s_rd |=> reg_rvalid)
        else $error("read at base gave no answer");
    AST_RD_ALIAS: assert property (reg_rd && reg_addr != 6'h38 |=> !reg_rvalid)
        else $error("read off base answered");
    AST_READBACK: assert property (s_wr ##2 (s_rd and (!reg_wr)) |=>
        reg_rdata == $past(reg_wdata, 3)) else $error("readback differs from write");
    AST_CLKOUT: assert property (s_wr |=> master_clock_out_pin_oe == !$past(reg_wdata[4]))
        else $error("clock out enable wrong");
    AST_READOUT: assert property (s_wr |=> cont_readout == $past(reg_wdata[2]) &&
        chain_readout == ($past(reg_wdata[3]) || $past(reg_wdata[2])))
        else $error("readout options wrong");
    AST_STANDBY: assert property (s_op(3'h3) |=> standby)
        else $error("standby not entered");
    AST_CAL_NOW: assert property (s_op(3'h4) |=> cal_active)
        else $error("calibration not entered at once");
    AST_CAL_END: assert property ($fell(done_n) && $past(cal_active) |-> adc_status == 8'hFF)
        else $error("calibration end without all ready");
    AST_DONE_STATUS: assert property ($fell(done_n) |-> adc_status != 8'h00)
        else $error("done without ready bit");
endmodule : amc_mode_ctrl_checker
bind amc_mode_ctrl amc_mode_ctrl_checker u_chk (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .master_clock_out_pin_oe(master_clock_out_pin_oe),
    .adc_status(adc_status), .done_n(done_n), .cal_active(cal_active), .standby(standby),
    .chain_readout(chain_readout), .cont_readout(cont_readout));

// *** amc_host_model.sv ***
// host model: drives the mode register bus
`timescale 1ns/1ps
module amc_host_model (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse so stale values cannot pass
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask : rd
endmodule : amc_host_model

// *** amc_mode_ctrl_tb_top.sv ***
// testbench top: host model, mode control block and scenario tasks
`timescale 1ns/1ps
module amc_mode_ctrl_tb_top;
    import amc_pkg::*;
    localparam logic [7:0] SG_MODE [5] = '{8'h42, 8'h40, 8'h43, 8'h43, 8'h42};
    localparam logic [1:0] SG_RANGE [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h1};
    localparam logic [23:0] SG_EXP [5] = '{24'h123456, 24'h001234, 24'hFFFFFF, 24'h000000,
        24'h123456};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic mclk = 1'b0;
    logic crystal_mode = 1'b0;
    logic conv_over = 1'b0;
    logic conv_under = 1'b0;
    logic [7:0] chan_enable = 8'h00;
    logic [23:0] conv_raw = 24'h123456;
    logic [23:0] got_data, chan_data;
    logic reg_wr, reg_rd, reg_rvalid, clk_o, clk_oe, done_n, cal_active, standby, dvalid;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, adc_status;
    logic [2:0] active_chan, data_idx;
    logic [1:0] conv_slot;
    int n_fail = 0;
    int n_compared = 0;
    always #2.5 clk = ~clk;
    always #7 mclk = ~mclk;
    amc_host_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    amc_mode_ctrl u_dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .chan_enable(chan_enable), .crystal_mode(crystal_mode),
        .master_clock_in_pin(mclk), .master_clock_out_pin_o(clk_o),
        .master_clock_out_pin_oe(clk_oe), .conv_raw(conv_raw), .conv_over(conv_over),
        .conv_under(conv_under), .adc_status(adc_status), .done_n(done_n),
        .active_chan(active_chan), .conv_slot(conv_slot), .cal_active(cal_active),
        .standby(standby), .chain_readout(), .cont_readout(), .chan_data(chan_data),
        .chan_data_idx(data_idx), .chan_data_valid(dvalid));
    task chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task finish_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    task wait_done(output int n);
        n = 0;
        got_data = 'x;
        #1;
        while (done_n !== 1'b0 && n < 300) begin
            @(posedge clk);
            #1;
            if (dvalid === 1'b1) got_data = chan_data;
            n++;
        end
    endtask : wait_done
    task readback(input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        u_host.rd(6'h38, d, ok);
        chk(ok, 1'b1);
        chk(d, exp);
    endtask : readback
    task t_reset;
        chk(done_n, 1'b1);
        chk(adc_status, 8'h00);
        chk(clk_oe, 1'b1);
        readback(8'h00);
    endtask : t_reset
    task t_ops;
        logic [2:0] op;
        logic [7:0] d;
        logic ok;
        for (int i = 0; i < 8; i++) begin
            op = i[2:0];
            u_host.wr({3'h7, op}, {op, 2'h0, op});
            #1;
            chk(standby, op == 3'h3);
            chk(cal_active, op[2]);
            if (op != 3'h0 && op != 3'h3 && op[2:1] != 2'h2) chk(active_chan, op);
            if (op[2:1] == 2'h2) chk(conv_slot, op[1:0]);
            readback({op, 2'h0, op});
        end
        u_host.rd(6'h3B, d, ok);
        chk(ok, 1'b0);
        u_host.wr(6'h38, 8'h00);
    endtask : t_ops
    task t_single;
        int n;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            conv_over <= SG_RANGE[i][0];
            conv_under <= SG_RANGE[i][1];
            u_host.wr(6'h3A, SG_MODE[i]);
            wait_done(n);
            chk(adc_status, 8'h04);
            chk(got_data, SG_EXP[i]);
            chk(data_idx, 3'h2);
            readback(SG_MODE[i] & 8'h1F);
        end
    endtask : t_single
    task t_abort;
        int n;
        u_host.wr(6'h38, 8'h80);
        #1;
        chk(done_n, 1'b1);
        chk(adc_status, 8'h00);
        repeat (20) @(posedge clk);
        u_host.wr(6'h3B, 8'h42);
        wait_done(n);
        chk(n < 80, 1'b1);
        chk(adc_status, 8'h08);
        u_host.wr(6'h38, 8'hE2);
        wait_done(n);
        chk(adc_status, 8'hFF);
        readback(8'h02);
    endtask : t_abort
    task t_cont;
        @(posedge clk) chan_enable <= 8'h0C;
        u_host.wr(6'h3A, 8'h26);
        repeat (300) @(posedge clk);
        #1;
        chk(adc_status, 8'h0C);
        readback(8'h26);
        u_host.wr(6'h38, 8'h00);
    endtask : t_cont
    task t_clock_out_disable;
        int n;
        u_host.wr(6'h3A, 8'h58);
        #1;
        chk(clk_oe, 1'b0);
        wait_done(n);
        chk(done_n, 1'b0);
        @(posedge clk) crystal_mode <= 1'b1;
        u_host.wr(6'h3A, 8'h58);
        wait_done(n);
        chk(done_n, 1'b1);
        readback(8'h58);
        @(posedge clk) crystal_mode <= 1'b0;
        u_host.wr(6'h38, 8'h00);
        #1;
        chk(clk_oe, 1'b1);
    endtask : t_clock_out_disable
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_ops;
        t_single;
        t_abort;
        t_cont;
        t_clock_out_disable;
        finish_test;
    end
    initial begin
        #50000;
        n_fail++;
        finish_test;
    end
endmodule : amc_mode_ctrl_tb_top
